// >>> verilog/acs_top.sv
// scan based channel transfer logic of a four input, two output loop current module
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acs_top #(
  parameter int NUM_IN = acs_pkg::NUM_IN,
  parameter int NUM_OUT = acs_pkg::NUM_OUT
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // loop currents from the front end, microamps, same clock
  input wire logic signed [16:0] cur_ua_0,
  input wire logic signed [16:0] cur_ua_1,
  input wire logic signed [16:0] cur_ua_2,
  input wire logic signed [16:0] cur_ua_3,
  // diagnostic pins from the board, asynchronous
  input wire logic noise_pin,
  input wire logic supply_fail_pin,
  // output channel codes to the converters
  output logic [11:0] dac_code_one,
  output logic [11:0] dac_code_two,
  output logic dac_load_one,
  output logic dac_load_two
);
  typedef struct packed {
    acs_pkg::acs_phase_t phase;
    logic [1:0] noise_sync;
    logic [1:0] fail_sync;
    logic [1:0] noise_meta;
    logic [3:0][11:0] code;
    logic [15:0] in_points;
    logic [15:0] out_points;
    logic [15:0] ctrl;
    logic [3:0][15:0] ptr_in;
    logic [1:0][11:0] ptr_out;
    logic [11:0] dac_one;
    logic [11:0] dac_two;
    logic load_one;
    logic load_two;
    logic [15:0] rdata;
  } acs_state_t;

  acs_state_t st_reg;
  acs_state_t st_next;
  logic [3:0][16:0] cur_vec;
  logic [3:0][11:0] conv_code;
  logic scan;
  logic ptr_mode;
  logic busy;
  logic failed;
  logic [1:0] pres;
  logic [11:0] pres_code;
  logic sel_one;
  logic sel_two;

  acs_seq_if sq ();

  assign cur_vec = {cur_ua_3, cur_ua_2, cur_ua_1, cur_ua_0};

  // one converter per input channel
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_conv
      acs_conv u_conv (
        .cur_ua(cur_vec[gi]),
        .code(conv_code[gi])
      );
    end
  endgenerate

  acs_in_seq u_seq (
    .clk(clk),
    .resetn(resetn),
    .sq(sq)
  );

  // a write to the scan word marks the host's end of scan
  assign scan = wr && addr == acs_pkg::OFS_SCAN;
  assign ptr_mode = st_reg.ctrl[acs_pkg::POS_PTR_MODE];
  assign sq.enable = st_reg.ctrl[acs_pkg::POS_IN_EN +: 4];
  // the sequencer only moves in multiplexing mode
  assign sq.step = scan && !ptr_mode;
  assign pres = sq.pick;

  // synchronised board flags; only the last stage of each chain is read
  assign failed = st_reg.fail_sync[1];
  assign busy = (st_reg.phase == acs_pkg::ACS_PH_FIRST) || st_reg.noise_sync[1];

  // a failed module reports zero data so stale counts are never mistaken for live ones
  assign pres_code = failed ? 12'h000 : st_reg.code[pres];

  // active-low selects; both low sends the same data to both channels
  assign sel_one = !st_reg.out_points[acs_pkg::POS_SEL_ONE_N];
  assign sel_two = !st_reg.out_points[acs_pkg::POS_SEL_TWO_N];

  always_comb begin
    st_next = st_reg;
    st_next.load_one = 1'b0;
    st_next.load_two = 1'b0;
    st_next.rdata = 16'h0000;

    // two flop synchroniser for the failure pin, four flops for the noise pin
    st_next.noise_meta = {st_reg.noise_meta[0], noise_pin};
    st_next.noise_sync = {st_reg.noise_sync[0], st_reg.noise_meta[1]};
    st_next.fail_sync = {st_reg.fail_sync[0], supply_fail_pin};

    // converted counts refresh every cycle, the host sees them only at scan
    st_next.code = conv_code;

    // register writes
    if (wr) begin
      unique case (addr)
        acs_pkg::OFS_OUT_POINTS: st_next.out_points = wdata;
        acs_pkg::OFS_CTRL: st_next.ctrl = wdata;
        acs_pkg::OFS_PTR_OUT0: st_next.ptr_out[0] = wdata[11:0];
        acs_pkg::OFS_PTR_OUT0 + 4'h1: st_next.ptr_out[1] = wdata[11:0];
        default: begin
        end
      endcase
    end

    // scan boundary transfers
    if (scan) begin
      if (!ptr_mode) begin
        // one channel per scan with its code on the two indicator points
        st_next.in_points = '0;
        st_next.in_points[11:0] = pres_code;
        st_next.in_points[acs_pkg::POS_CODE_HIGH] = pres[1];
        st_next.in_points[acs_pkg::POS_CODE_LOW] = pres[0];
        st_next.in_points[acs_pkg::POS_BUSY] = busy;
        st_next.in_points[acs_pkg::POS_FAIL] = failed;
        // one output word per scan, routed by the selects
        if (sel_one) begin
          st_next.dac_one = st_reg.out_points[11:0];
          st_next.load_one = 1'b1;
        end
        if (sel_two) begin
          st_next.dac_two = st_reg.out_points[11:0];
          st_next.load_two = 1'b1;
        end
      end else begin
        // every channel in the same scan
        for (int c = 0; c < 4; c++) begin
          if (busy) begin
            st_next.ptr_in[c] = acs_pkg::BUSY_PTR_WORD;
          end else if (failed) begin
            st_next.ptr_in[c] = 16'h0000;
          end else begin
            st_next.ptr_in[c] = {4'h0, st_reg.code[c]};
          end
        end
        st_next.in_points = '0;
        st_next.in_points[acs_pkg::POS_BUSY] = busy;
        st_next.in_points[acs_pkg::POS_FAIL] = failed;
        st_next.dac_one = st_reg.ptr_out[0];
        st_next.dac_two = st_reg.ptr_out[1];
        st_next.load_one = 1'b1;
        st_next.load_two = 1'b1;
      end
      // the first scan is over once its transfer has been made
      st_next.phase = acs_pkg::ACS_PH_RUN;
    end

    // read data stand in the cycle after the strobe, unmapped words read zero
    if (rd) begin
      unique case (addr)
        acs_pkg::OFS_IN_POINTS: st_next.rdata = st_reg.in_points;
        acs_pkg::OFS_OUT_POINTS: st_next.rdata = st_reg.out_points;
        acs_pkg::OFS_CTRL: st_next.rdata = st_reg.ctrl;
        acs_pkg::OFS_PTR_IN0: st_next.rdata = st_reg.ptr_in[0];
        acs_pkg::OFS_PTR_IN0 + 4'h1: st_next.rdata = st_reg.ptr_in[1];
        acs_pkg::OFS_PTR_IN0 + 4'h2: st_next.rdata = st_reg.ptr_in[2];
        acs_pkg::OFS_PTR_IN0 + 4'h3: st_next.rdata = st_reg.ptr_in[3];
        acs_pkg::OFS_PTR_OUT0: st_next.rdata = {4'h0, st_reg.ptr_out[0]};
        acs_pkg::OFS_PTR_OUT0 + 4'h1: st_next.rdata = {4'h0, st_reg.ptr_out[1]};
        default: st_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.phase <= acs_pkg::ACS_PH_FIRST;
      st_reg.ctrl <= acs_pkg::CTRL_RST;
      st_reg.out_points <= acs_pkg::OUT_POINTS_RST;
      // busy shows in the input point word until the second scan, as the first scan's transfer still carries it
      st_reg.in_points <= 16'h4000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign dac_code_one = st_reg.dac_one;
  assign dac_code_two = st_reg.dac_two;
  assign dac_load_one = st_reg.load_one;
  assign dac_load_two = st_reg.load_two;
endmodule
`default_nettype wire

// >>> common/acs_pkg.sv
// shared constants and types of the analog combo channel scan block
package acs_pkg;
  // sizes of the module's host image
  localparam int NUM_IN = 4;
  localparam int NUM_OUT = 2;
  localparam int CODE_W = 12;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 4;
  localparam int CUR_W = 17;

  // word addresses on the register port
  localparam logic [3:0] OFS_IN_POINTS = 4'h0;
  localparam logic [3:0] OFS_OUT_POINTS = 4'h1;
  localparam logic [3:0] OFS_CTRL = 4'h2;
  localparam logic [3:0] OFS_SCAN = 4'h3;
  localparam logic [3:0] OFS_PTR_IN0 = 4'h4;
  localparam logic [3:0] OFS_PTR_OUT0 = 4'h8;

  // field positions inside the 16 bit point and control words
  localparam int POS_CODE_HIGH = 12;
  localparam int POS_CODE_LOW = 13;
  localparam int POS_BUSY = 14;
  localparam int POS_FAIL = 15;
  localparam int POS_SEL_TWO_N = 12;
  localparam int POS_SEL_ONE_N = 13;
  localparam int POS_PTR_MODE = 0;
  localparam int POS_IN_EN = 4;

  // reset values, the busy pointer word and the count ceiling
  localparam logic [15:0] CTRL_RST = 16'h00F0;
  localparam logic [15:0] OUT_POINTS_RST = 16'h3000;
  localparam logic [15:0] BUSY_PTR_WORD = 16'h8000;
  localparam logic [11:0] CODE_MAX = 12'hFFF;

  // loop current figures in microamps
  localparam int I_ZERO_UA = 4000;
  localparam int I_SPAN_UA = 16000;
  localparam int CODE_STEPS = 4095;

  typedef enum logic [1:0] {
    ACS_PH_FIRST = 2'b01,
    ACS_PH_RUN = 2'b10
  } acs_phase_t;
endpackage

// >>> common/acs_seq_if.sv
// carrier between the scan controller and the input channel sequencer
`timescale 1ns/1ps
`default_nettype none
interface acs_seq_if;
  logic [3:0] enable;
  logic step;
  logic [1:0] pick;
  modport ctl (output enable, output step, input pick);
  modport seq (input enable, input step, output pick);
endinterface
`default_nettype wire

// >>> verilog/acs_conv.sv
// loop current to twelve bit count converter for one input channel
`timescale 1ns/1ps
`default_nettype none
module acs_conv (
  // measured loop current, microamps, signed
  input wire logic signed [16:0] cur_ua,
  // converted count
  output logic [11:0] code
);
  logic [31:0] mag;
  logic [31:0] scaled;
  logic rev;

  always_comb begin
    rev = 1'b0;
    mag = 32'h0;
    if (cur_ua >= 17'(acs_pkg::I_ZERO_UA)) begin
      mag = 32'(cur_ua) - 32'(acs_pkg::I_ZERO_UA);
    end else if (cur_ua <= -17'(acs_pkg::I_ZERO_UA)) begin
      // reversed wiring beyond 4 mA folds back into a wrong, non-zero count
      rev = 1'b1;
      mag = 32'(-cur_ua) - 32'(acs_pkg::I_ZERO_UA);
    end
    scaled = (mag * 32'(acs_pkg::CODE_STEPS)) / 32'(acs_pkg::I_SPAN_UA);
    if (scaled > 32'(acs_pkg::CODE_MAX)) begin
      code = acs_pkg::CODE_MAX;
    end else if (rev && scaled == 32'h0) begin
      code = 12'h001;
    end else begin
      code = scaled[11:0];
    end
  end
endmodule
`default_nettype wire

// >>> verilog/acs_in_seq.sv
// multiplexed input channel sequencer: picks the next channel in use
`timescale 1ns/1ps
`default_nettype none
module acs_in_seq (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // controller side
  acs_seq_if.seq sq
);
  typedef struct packed {
    logic [1:0] chan;
  } acs_seq_state_t;

  acs_seq_state_t st_reg;
  acs_seq_state_t st_next;
  logic [1:0] pick;
  logic [1:0] probe;

  // first channel in use at or after the current one, wrapping past the last
  always_comb begin
    pick = st_reg.chan;
    probe = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      probe = st_reg.chan + 2'(k);
      if (sq.enable[probe]) begin
        pick = probe;
      end
    end
  end

  always_comb begin
    st_next = st_reg;
    if (sq.step) begin
      st_next.chan = pick + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sq.pick = pick;
endmodule
`default_nettype wire

// >>> tb/acs_top_sva.sv
// port checker of the scan transfer block
`timescale 1ns/1ps
`default_nettype none
module acs_top_sva #(
  parameter int NUM_IN = 4,
  parameter int NUM_OUT = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [3:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // output channels
  input wire logic [11:0] dac_code_one,
  input wire logic [11:0] dac_code_two,
  input wire logic dac_load_one,
  input wire logic dac_load_two
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data not idle");
  AST_UNMAPPED: assert property (rd && addr == 4'hF |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_SCAN_RD0: assert property (rd && addr == acs_pkg::OFS_SCAN |=> rdata == 16'h0000)
    else $error("scan word read not zero");
  AST_PTR_RANGE: assert property (rd && addr[3:2] == 2'b01 |=>
    rdata[15:12] == 4'h0 || rdata == 16'h8000) else $error("pointer word out of range");
  AST_FAIL_ZERO: assert property (rd && addr == acs_pkg::OFS_IN_POINTS |=>
    !rdata[15] || rdata[11:0] == 12'h000) else $error("failure with data");
  AST_LOAD_ONE: assert property (dac_load_one |-> $past(wr) &&
    $past(addr) == acs_pkg::OFS_SCAN) else $error("load one without scan");
  AST_LOAD_TWO: assert property (dac_load_two |-> $past(wr) &&
    $past(addr) == acs_pkg::OFS_SCAN) else $error("load two without scan");
  AST_HOLD_ONE: assert property (!dac_load_one |-> $stable(dac_code_one))
    else $error("code one moved without load");
  AST_HOLD_TWO: assert property (!dac_load_two |-> $stable(dac_code_two))
    else $error("code two moved without load");
endmodule
bind acs_top acs_top_sva #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) acs_top_sva_inst (
  .clk(clk), .resetn(resetn), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
  .dac_code_one(dac_code_one), .dac_code_two(dac_code_two),
  .dac_load_one(dac_load_one), .dac_load_two(dac_load_two));
`default_nettype wire

// >>> tb/acs_host_model.sv
// host model: a bus master moving one whole word per call
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
  // clock
  input wire logic clk,
  // register port as the host drives it
  output logic [3:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // whole words only, so the image always sits on word boundaries
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_analog_combo_channel_scan.sv
// self-checking bench of the scan transfer block
`timescale 1ns/1ps
`default_nettype none
module tb_analog_combo_channel_scan;
  logic clk;
  logic resetn;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic wr, rd, load_one, load_two;
  logic rd_seen = 1'b0;
  // board diagnostic pins, driven so busy and failure paths are reached
  logic noise = 1'b0;
  logic fail = 1'b0;
  logic [15:0] rdata;
  logic [11:0] code_one, code_two, v;
  logic signed [16:0] cu [0:3];
  logic [15:0] q_rd [$];
  logic [11:0] q_one [$];
  logic [11:0] q_two [$];
  // selects per output step: {one_n, two_n}
  logic [1:0] sel [0:4] = '{2'b01, 2'b01, 2'b10, 2'b00, 2'b11};
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 32'h76EE;
  int k;
  acs_top acs_top_inst (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cur_ua_0(cu[0]), .cur_ua_1(cu[1]), .cur_ua_2(cu[2]),
    .cur_ua_3(cu[3]), .noise_pin(noise), .supply_fail_pin(fail), .dac_code_one(code_one),
    .dac_code_two(code_two), .dac_load_one(load_one), .dac_load_two(load_two));
  acs_host_model acs_host_model_inst (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    tests_run++;
    if (e !== s) begin
      $display("FAIL %s expected %h seen %h", n, e, s);
      n_mismatch++;
    end
  endtask
  function automatic logic [11:0] conv(int i);
    int m;
    m = (i < 0) ? -i : i;
    if (m < 4000) return 12'h000;
    m = (m - 4000) * 4095 / 16000;
    if (m > 4095) m = 4095;
    if (i < 0 && m == 0) m = 1;
    return m[11:0];
  endfunction
  function automatic logic [15:0] in_word(int c);
    logic [1:0] kk;
    kk = c[1:0];
    return {2'b00, kk[0], kk[1], conv(cu[c])};
  endfunction
  task automatic rd_chk(logic [3:0] a, logic [15:0] e);
    q_rd.push_back(e);
    acs_host_model_inst.bus_rd(a);
  endtask
  task automatic put_word(logic [3:0] a, logic [15:0] d);
    acs_host_model_inst.bus_wr(a, d);
  endtask
  task automatic scan;
    acs_host_model_inst.bus_wr(acs_pkg::OFS_SCAN, 16'h0001);
  endtask
  task automatic set_cur;
    for (int i = 0; i < 4; i++) cu[i] <= 17'(4000 + ($random(seed) & 32'h3FFF));
  endtask
  // an empty queue yields unknown, so a stray result always mismatches
  always @(posedge clk) begin
    if (rd_seen) chk("rdata", q_rd.size() ? q_rd.pop_front() : 16'hXXXX, rdata);
    rd_seen <= rd;
    if (load_one === 1'b1) chk("code_one",
      {4'h0, q_one.size() ? q_one.pop_front() : 12'hXXX}, {4'h0, code_one});
    if (load_two === 1'b1) chk("code_two",
      {4'h0, q_two.size() ? q_two.pop_front() : 12'hXXX}, {4'h0, code_two});
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    resetn = 1'b0;
    for (k = 0; k < 4; k++) cu[k] = 17'h00000;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(acs_pkg::OFS_CTRL, acs_pkg::CTRL_RST);
    rd_chk(acs_pkg::OFS_OUT_POINTS, acs_pkg::OUT_POINTS_RST);
    rd_chk(acs_pkg::OFS_IN_POINTS, 16'h4000);
    rd_chk(4'hF, 16'h0000);
    set_cur();
    scan();
    $display("test reset done");
    for (k = 1; k <= 5; k++) begin
      scan();
      rd_chk(acs_pkg::OFS_IN_POINTS, in_word(k % 4));
    end
    $display("test multiplex input done");
    put_word(acs_pkg::OFS_CTRL, 16'h0050);
    cu[0] <= 17'h1F448;
    cu[2] <= 17'h1D120;
    for (k = 0; k < 3; k++) begin
      scan();
      rd_chk(acs_pkg::OFS_IN_POINTS, in_word((k % 2) ? 0 : 2));
    end
    $display("test skip and reversed done");
    put_word(acs_pkg::OFS_CTRL, 16'h00F0);
    for (k = 0; k < 5; k++) begin
      v = 12'($random(seed));
      if (!sel[k][1]) q_one.push_back(v);
      if (!sel[k][0]) q_two.push_back(v);
      put_word(acs_pkg::OFS_OUT_POINTS, {2'b00, sel[k], v});
      scan();
    end
    $display("test multiplex output done");
    set_cur();
    put_word(acs_pkg::OFS_CTRL, 16'h00F1);
    v = 12'($random(seed));
    put_word(acs_pkg::OFS_PTR_OUT0, {4'h0, v});
    put_word(acs_pkg::OFS_PTR_OUT0 + 4'h1, {4'h0, ~v});
    repeat (2) begin
      q_one.push_back(v);
      q_two.push_back(~v);
      scan();
    end
    for (k = 0; k < 4; k++) rd_chk(acs_pkg::OFS_PTR_IN0 + 4'(k), {4'h0, conv(cu[k])});
    repeat (4) @(posedge clk);
    $display("test pointer done");
    // the pins pass a synchroniser chain, so wait well past it before scanning
    noise <= 1'b1;
    repeat (6) @(posedge clk);
    q_one.push_back(v);
    q_two.push_back(~v);
    scan();
    rd_chk(acs_pkg::OFS_PTR_IN0 + 4'h2, acs_pkg::BUSY_PTR_WORD);
    rd_chk(acs_pkg::OFS_IN_POINTS, 16'h4000);
    noise <= 1'b0;
    fail <= 1'b1;
    repeat (6) @(posedge clk);
    q_one.push_back(v);
    q_two.push_back(~v);
    scan();
    rd_chk(acs_pkg::OFS_PTR_IN0 + 4'h1, 16'h0000);
    rd_chk(acs_pkg::OFS_IN_POINTS, 16'h8000);
    repeat (4) @(posedge clk);
    // every noted result must have shown up
    chk("queues", 16'h0000, 16'(q_rd.size() + q_one.size() + q_two.size()));
    $display("test diagnostics done");
    report_and_stop();
  end
endmodule
`default_nettype wire
